// File: dma_pkg.sv
package dma_pkg;

	// Widths and depths.
	localparam int NUM_CH     = 8;
	localparam int CH_W       = 3;
	localparam int CNT_W      = 16;
	localparam int DATA_W     = 32;
	localparam int FIFO_DEPTH = 4;
	localparam int WAIT_W     = 4;
	localparam int CYC_W      = 5;
	localparam int PIECE_W    = 5;
	localparam int IRQ_W      = 4;

	// Recognition latencies in bus clock periods.
	localparam int EXT_REQ_LAT = 4;
	localparam int PERIPH_LAT  = 2;
	localparam int NMI_LAT     = 2;

	// On-chip RAM access lengths in bus clock periods.
	localparam logic [CYC_W-1:0] RAM_RD_FULL = 5'h03;
	localparam logic [CYC_W-1:0] RAM_WR_FULL = 5'h02;
	localparam logic [CYC_W-1:0] RAM_RD_MID  = 5'h02;
	localparam logic [CYC_W-1:0] RAM_WR_MID  = 5'h02;
	localparam logic [CYC_W-1:0] RAM_SLOW    = 5'h01;

	// Values after reset.
	localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;

	typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG, SIZE_16B}
		xfer_size_t;
	typedef enum logic [1:0] {WIDTH_8, WIDTH_16, WIDTH_32} dev_width_t;
	typedef enum logic [1:0] {MEM_NORMAL, MEM_MPX, MEM_BURST_MPX, MEM_ONCHIP}
		mem_type_t;
	typedef enum logic [1:0] {RATIO_1_1, RATIO_1_2, RATIO_1_4, RATIO_SLOWER}
		clk_ratio_t;
	typedef enum {S_IDLE, S_ADDR, S_ACCESS, S_GAP} eng_state_t;

	typedef struct packed {
		logic       channelEnable;
		logic       requestEdgeSelect;
		logic       finishIrqEnable;
		logic       halfDoneIrqEnable;
		logic       periphSource;
		logic       reloadOn;
		logic       readAccess;
		xfer_size_t size;
		dev_width_t width;
		mem_type_t  memType;
	} chan_cfg_t;

	typedef struct packed {
		logic chipSelect;
		logic requestAck;
		logic transferEnd;
	} bus_pins_t;

endpackage

// File: dma_request_timing_and_irq.sv
`timescale 1ns/1ps
// Notes on behaviour
// - External bus cycle length uses the same wait settings as processor cycles.
// - Split a unit into several bus cycles when it is wider than the device.
// - With chip select negated between pieces, acknowledge and end pulse per piece.
// - Level request with split acknowledge may overrun by one transfer at most.
// - Each channel has separate finish and half-way interrupt lines.
// - Finish interrupt is requested while end flag and its enable are both set.
// - Half interrupt is requested while half flag and its enable are both set.
// - Clearing an interrupt flag to zero withdraws the matching request.
// - Lower channel ranks first, finish above half within a channel; channel 0 finish highest, channel 7 half lowest.
// - For multiplexed address/data memory, acknowledge asserts in the data phase.
// - For all other memory, acknowledge follows the chip select timing.
// - Transfer end output always follows the chip select timing.
// - NMI beats a simultaneous activation: flag set, channel not started.
// - NMI stop is recognised within two bus clock periods.
// - External pin activation is recognised in four bus clock periods.
// - Peripheral activation is recognised in one bus plus one peripheral period.
// - On-chip RAM cycles: 1:1 read 3 write 2; 1/2, 1/4 two; slower one.

module dma_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      used_q;
	logic             wrEn;
	logic             rdEn;

	assign inReady  = used_q != (AW+1)'(DEPTH);
	assign outValid = used_q != '0;
	assign outData  = mem[rdPtr_q];
	assign wrEn     = inValid & inReady;
	assign rdEn     = outValid & outReady;

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			used_q  <= '0;
		end else begin
			if (wrEn) begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (rdEn) begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			end
			used_q <= used_q + {{AW{1'b0}}, wrEn} - {{AW{1'b0}}, rdEn};
		end
	end
endmodule

module dma_request_timing_and_irq import dma_pkg::*; (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Channel settings
	input  wire chan_cfg_t           chanCfg [NUM_CH],
	input  wire logic [CNT_W-1:0]    countInit [NUM_CH],
	input  wire logic [CNT_W-1:0]    reloadCount [NUM_CH],
	input  wire logic [NUM_CH-1:0]   countLoad,
	// Bus state controller settings
	input  wire logic [WAIT_W-1:0]   waitStates,
	input  wire logic                csNegateBetween,
	input  wire clk_ratio_t          clkRatio,
	// Transfer requests
	input  wire logic [NUM_CH-1:0]   transferRequest_n,
	input  wire logic [NUM_CH-1:0]   periphRequest,
	// Non-maskable interrupt
	input  wire logic                nmiPin,
	input  wire logic                nmiFlagClear,
	output logic                     nmiFlag,
	// Flags and interrupts
	input  wire logic [NUM_CH-1:0]   transferEndFlagClear,
	input  wire logic [NUM_CH-1:0]   halfDoneFlagClear,
	output logic [NUM_CH-1:0]        transferEndFlag,
	output logic [NUM_CH-1:0]        halfDoneFlag,
	output logic [NUM_CH-1:0]        finishInterrupt,
	output logic [NUM_CH-1:0]        halfInterrupt,
	output logic                     topIrqValid,
	output logic [IRQ_W-1:0]         topIrqSource,
	// External bus
	output bus_pins_t                busPins,
	output logic                     busActive,
	output logic [CH_W-1:0]          busChannel,
	input  wire logic [DATA_W-1:0]   busRdData,
	// Read data stream
	output logic                     streamValid,
	input  wire logic                streamReady,
	output logic [DATA_W-1:0]        streamData
);
	eng_state_t          state_q;
	logic [CH_W-1:0]     curCh_q;
	logic [PIECE_W-1:0]  piecesLeft_q;
	logic [CYC_W-1:0]    cycLeft_q;
	logic [NUM_CH-1:0]   pending_q;
	logic [NUM_CH-1:0]   teFlag_q;
	logic [NUM_CH-1:0]   heFlag_q;
	logic [NUM_CH-1:0]   unitDone;
	logic [CNT_W-1:0]    count_q [NUM_CH];
	logic [CNT_W-1:0]    halfMark_q [NUM_CH];
	logic                nmiSync1_q;
	logic                nmiSync2_q;
	logic                nmiPrev_q;
	logic                nmiFlag_q;
	logic                nmiEvent;
	logic                nmiBlock;
	logic                grantValid;
	logic                grantGo;
	logic [CH_W-1:0]     grantCh;
	chan_cfg_t           cur;
	chan_cfg_t           nxt;
	logic                curMpx;
	logic                curExt;
	logic                pieceEnd;
	logic                lastPiece;
	logic                fifoInReady;

	function automatic logic isMpx(mem_type_t m);
		return (m == MEM_MPX) || (m == MEM_BURST_MPX);
	endfunction

	// Bus cycles needed for one transfer unit.
	function automatic logic [PIECE_W-1:0] pieceCount(chan_cfg_t c);
		logic [2:0] u;
		logic [2:0] d;
		u = (c.size == SIZE_16B) ? 3'h4 : {1'b0, c.size};
		d = {1'b0, c.width};
		if (c.memType == MEM_ONCHIP || u <= d) begin
			return PIECE_W'(1);
		end
		return PIECE_W'(1) << (u - d);
	endfunction

	// Length of one bus cycle in bus clock periods.
	function automatic logic [CYC_W-1:0] cycLen(chan_cfg_t c, clk_ratio_t r,
			logic [WAIT_W-1:0] w);
		if (c.memType != MEM_ONCHIP) begin
			return {1'b0, w} + 5'h01;
		end
		unique case (r)
			RATIO_1_1: return c.readAccess ? RAM_RD_FULL : RAM_WR_FULL;
			RATIO_1_2,
			RATIO_1_4: return c.readAccess ? RAM_RD_MID : RAM_WR_MID;
			RATIO_SLOWER: return RAM_SLOW;
		endcase
	endfunction

	assign cur       = chanCfg[curCh_q];
	assign nxt       = chanCfg[grantCh];
	assign curMpx    = isMpx(cur.memType);
	assign curExt    = cur.memType != MEM_ONCHIP;
	assign lastPiece = piecesLeft_q == PIECE_W'(1);
	// A read piece cannot end while the buffer is full, so the stall
	// stretches the bus cycle instead of dropping data.
	assign pieceEnd  = (state_q == S_ACCESS) && (cycLeft_q == CYC_W'(1))
		&& (!cur.readAccess || fifoInReady);

	// NMI synchroniser and flag; a new NMI wins over a clear.
	assign nmiEvent = nmiSync2_q & ~nmiPrev_q;
	assign nmiBlock = nmiEvent | nmiFlag_q;
	assign nmiFlag  = nmiFlag_q;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			nmiSync1_q <= 1'b0;
			nmiSync2_q <= 1'b0;
			nmiPrev_q  <= 1'b0;
		end else begin
			nmiSync1_q <= nmiPin;
			nmiSync2_q <= nmiSync1_q;
			nmiPrev_q  <= nmiSync2_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			nmiFlag_q <= 1'b0;
		end else if (nmiEvent) begin
			nmiFlag_q <= 1'b1;
		end else if (nmiFlagClear) begin
			nmiFlag_q <= 1'b0;
		end
	end

	// Fixed channel order: the lowest pending channel wins.
	always_comb begin
		grantValid = 1'b0;
		grantCh    = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (pending_q[i]) begin
				grantValid = 1'b1;
				grantCh    = CH_W'(i);
			end
		end
	end

	assign grantGo = grantValid && state_q == S_IDLE && !nmiBlock
		&& fifoInReady;

	// Bus engine.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q      <= S_IDLE;
			curCh_q      <= '0;
			piecesLeft_q <= '0;
			cycLeft_q    <= '0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (grantGo) begin
						curCh_q      <= grantCh;
						piecesLeft_q <= pieceCount(nxt);
						cycLeft_q    <= cycLen(nxt, clkRatio, waitStates);
						state_q      <= isMpx(nxt.memType) ? S_ADDR : S_ACCESS;
					end
				end
				S_ADDR: begin
					state_q <= S_ACCESS;
				end
				S_ACCESS: begin
					if (pieceEnd && lastPiece) begin
						state_q <= S_IDLE;
					end else if (pieceEnd) begin
						piecesLeft_q <= piecesLeft_q - PIECE_W'(1);
						cycLeft_q    <= cycLen(cur, clkRatio, waitStates);
						if (csNegateBetween && curExt) begin
							state_q <= S_GAP;
						end else if (curMpx) begin
							state_q <= S_ADDR;
						end
					end else if (cycLeft_q > CYC_W'(1)) begin
						cycLeft_q <= cycLeft_q - CYC_W'(1);
					end
				end
				S_GAP: begin
					state_q <= curMpx ? S_ADDR : S_ACCESS;
				end
			endcase
		end
	end

	// Pins follow the engine state; on-chip RAM cycles drive no pins.
	always_comb begin
		busPins.chipSelect  = curExt
			&& (state_q == S_ADDR || state_q == S_ACCESS);
		busPins.requestAck  = curMpx ? (state_q == S_ACCESS)
			: busPins.chipSelect;
		busPins.transferEnd = busPins.chipSelect
			&& count_q[curCh_q] == CNT_W'(1);
	end

	assign busActive  = state_q != S_IDLE;
	assign busChannel = curCh_q;

	dma_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) readBuffer (
		.clk      (clk),
		.reset_n  (reset_n),
		.inValid  (pieceEnd && cur.readAccess),
		.inReady  (fifoInReady),
		.inData   (busRdData),
		.outValid (streamValid),
		.outReady (streamReady),
		.outData  (streamData)
	);

	// Per-channel request detection, counting and flags.
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		logic reqSync1_q;
		logic reqSync2_q;
		logic reqStage3_q;
		logic reqStage4_q;
		logic periphStage_q;
		logic extTrig;
		logic trig;
		logic busyHere;
		logic canAct;
		logic [CNT_W-1:0] countNext;

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				reqSync1_q    <= 1'b0;
				reqSync2_q    <= 1'b0;
				reqStage3_q   <= 1'b0;
				reqStage4_q   <= 1'b0;
				periphStage_q <= 1'b0;
			end else begin
				reqSync1_q    <= ~transferRequest_n[i];
				reqSync2_q    <= reqSync1_q;
				reqStage3_q   <= reqSync2_q;
				reqStage4_q   <= reqStage3_q;
				periphStage_q <= periphRequest[i];
			end
		end

		assign extTrig  = chanCfg[i].requestEdgeSelect
			? (reqStage3_q & ~reqStage4_q) : reqStage3_q;
		assign trig     = chanCfg[i].periphSource ? periphStage_q : extTrig;
		assign busyHere = state_q != S_IDLE && curCh_q == CH_W'(i);
		assign canAct   = chanCfg[i].channelEnable && !teFlag_q[i] && !nmiBlock;
		assign unitDone[i] = pieceEnd && lastPiece && curCh_q == CH_W'(i);
		assign countNext   = count_q[i] - CNT_W'(1);

		// A level request is looked at again only once the unit is over,
		// which is where the single overrun comes from.
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				pending_q[i] <= 1'b0;
			end else if (!chanCfg[i].channelEnable) begin
				pending_q[i] <= 1'b0;
			end else if (grantGo && grantCh == CH_W'(i)) begin
				pending_q[i] <= 1'b0;
			end else if (trig && canAct && (chanCfg[i].requestEdgeSelect
					|| chanCfg[i].periphSource || !busyHere)) begin
				pending_q[i] <= 1'b1;
			end
		end

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				count_q[i]    <= COUNT_RESET;
				halfMark_q[i] <= COUNT_RESET;
			end else if (countLoad[i]) begin
				count_q[i]    <= countInit[i];
				halfMark_q[i] <= countInit[i] >> 1;
			end else if (unitDone[i] && countNext == '0
					&& chanCfg[i].reloadOn) begin
				count_q[i]    <= reloadCount[i];
				halfMark_q[i] <= reloadCount[i] >> 1;
			end else if (unitDone[i]) begin
				count_q[i] <= countNext;
			end
		end

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				teFlag_q[i] <= 1'b0;
			end else if (unitDone[i] && countNext == '0) begin
				teFlag_q[i] <= 1'b1;
			end else if (transferEndFlagClear[i]) begin
				teFlag_q[i] <= 1'b0;
			end
		end

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				heFlag_q[i] <= 1'b0;
			end else if (unitDone[i] && countNext == halfMark_q[i]) begin
				heFlag_q[i] <= 1'b1;
			end else if (halfDoneFlagClear[i]) begin
				heFlag_q[i] <= 1'b0;
			end
		end

		assign finishInterrupt[i] = teFlag_q[i]
			& chanCfg[i].finishIrqEnable;
		assign halfInterrupt[i]   = heFlag_q[i]
			& chanCfg[i].halfDoneIrqEnable;

		a_finish_irq_set: assert property (@(posedge clk) disable iff (!reset_n)
			unitDone[i] && countNext == '0 && chanCfg[i].finishIrqEnable
			|=> finishInterrupt[i])
			else $error("finish interrupt missing after last unit");

		a_half_irq_set: assert property (@(posedge clk) disable iff (!reset_n)
			unitDone[i] && countNext == halfMark_q[i]
			&& chanCfg[i].halfDoneIrqEnable
			|=> halfInterrupt[i])
			else $error("half interrupt missing with flag set");

		a_flag_clear_drop: assert property (@(posedge clk) disable iff (!reset_n)
			transferEndFlagClear[i] && !unitDone[i] |=> !finishInterrupt[i])
			else $error("finish interrupt kept after clear");

		a_ext_req_latency: assert property (@(posedge clk) disable iff (!reset_n)
			$rose(pending_q[i]) && !chanCfg[i].periphSource
			&& chanCfg[i].requestEdgeSelect
			|-> !$past(transferRequest_n[i], 4)
			&& $past(transferRequest_n[i], 5))
			else $error("pin request not recognised after four cycles");

		a_periph_latency: assert property (@(posedge clk) disable iff (!reset_n)
			$rose(pending_q[i]) && chanCfg[i].periphSource
			|-> $past(periphRequest[i], 2))
			else $error("peripheral request not recognised after two cycles");
	end

	assign transferEndFlag = teFlag_q;
	assign halfDoneFlag    = heFlag_q;

	// Highest pending source: lower channel first, finish above half within a channel.
	always_comb begin
		topIrqValid  = 1'b0;
		topIrqSource = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (halfInterrupt[i]) begin
				topIrqValid  = 1'b1;
				topIrqSource = IRQ_W'(2 * i + 1);
			end
			if (finishInterrupt[i]) begin
				topIrqValid  = 1'b1;
				topIrqSource = IRQ_W'(2 * i);
			end
		end
	end

	a_nmi_stop_latency: assert property (@(posedge clk) disable iff (!reset_n)
		$past(nmiPin, 2) && !$past(nmiPin, 3) |-> !grantGo)
		else $error("activation not stopped two cycles after NMI");

	a_nmi_holds_idle: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == S_IDLE && nmiFlag_q |=> state_q == S_IDLE)
		else $error("channel activated while NMI flag set");

	a_mpx_ack_data: assert property (@(posedge clk) disable iff (!reset_n)
		busPins.requestAck && curMpx |-> state_q == S_ACCESS
		&& $past(state_q) != S_IDLE)
		else $error("multiplexed acknowledge outside data phase");

	a_ack_follows_cs: assert property (@(posedge clk) disable iff (!reset_n)
		!curMpx |-> busPins.requestAck == busPins.chipSelect)
		else $error("acknowledge differs from chip select");

	a_transfer_end_output_follows_cs: assert property (@(posedge clk) disable iff (!reset_n)
		busPins.transferEnd |-> busPins.chipSelect)
		else $error("transfer end asserted without chip select");

	a_split_gap: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == S_GAP |-> !busPins.chipSelect && !busPins.requestAck
		&& !busPins.transferEnd ##1 state_q != S_GAP)
		else $error("strobes not split between pieces");

	a_ram_read_full: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == S_IDLE && grantGo && nxt.memType == MEM_ONCHIP
		&& nxt.readAccess && clkRatio == RATIO_1_1
		|=> (state_q == S_ACCESS) [*3])
		else $error("on-chip RAM read at 1:1 shorter than three cycles");
endmodule

// File: dma_ext_partner.sv
`timescale 1ns/1ps
// Far-side device: drives the request pins from the bench's wishes and
// answers reads with a numbered word per chip-select piece.
module dma_ext_partner import dma_pkg::*; (
	// Clock and bench control
	input  wire logic              clk,
	input  wire logic [NUM_CH-1:0] want,
	// Pins facing the device
	input  wire bus_pins_t         busPins,
	output logic [NUM_CH-1:0]      transferRequest_n,
	output logic [DATA_W-1:0]      busRdData,
	output logic [15:0]            pieces
);
	logic [DATA_W-1:0] lastData = 32'h0;
	logic              csSeen   = 1'b0;

	initial pieces = 16'h0;
	initial transferRequest_n = '1;

	// Pins change only after a rising edge, and a wish is raised only once
	// the channel settings are complete.
	always @(posedge clk) transferRequest_n <= ~want;

	// A deselected device no longer holds the bus, so the inverse of the
	// last word is shown to expose a late capture.
	always_comb busRdData = busPins.chipSelect ?
		32'ha5000000 + pieces : ~lastData;

	always @(posedge clk) begin
		csSeen <= busPins.chipSelect;
		if (busPins.chipSelect)
			lastData <= busRdData;
		if (csSeen && !busPins.chipSelect)
			pieces <= pieces + 16'h1;
	end
endmodule

// File: dma_request_timing_and_irq_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin \
	badCount++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module dma_request_timing_and_irq_tb import dma_pkg::*;;
	logic              clk     = 1'b0;
	logic              reset_n = 1'b0;
	chan_cfg_t         cfg [NUM_CH];
	logic [CNT_W-1:0]  cInit [NUM_CH];
	logic [CNT_W-1:0]  rCnt [NUM_CH];
	logic [NUM_CH-1:0] load  = '0;
	logic [NUM_CH-1:0] pReq  = '0;
	logic [NUM_CH-1:0] teClr = '0;
	logic [NUM_CH-1:0] hdClr = '0;
	logic [NUM_CH-1:0] want  = '0;
	logic [WAIT_W-1:0] ws    = '0;
	logic              nmiPin = 1'b0;
	logic              nmiClr = 1'b0;
	logic              sRdy   = 1'b1;
	clk_ratio_t        ratio  = RATIO_1_1;
	logic [NUM_CH-1:0] reqN, teFlag, hdFlag, finIrq, halfIrq;
	logic              nmiFlag, topValid, busAct, sValid;
	logic [IRQ_W-1:0]  topSrc;
	bus_pins_t         pins;
	logic [CH_W-1:0]   busCh;
	logic [DATA_W-1:0] rdData, sData;
	logic [15:0]       pieces;
	int                badCount = 0;
	int                nChecks  = 0;
	int                cyc      = 0;
	int                csH, ackH, tdH, csUp, actH;

	dma_request_timing_and_irq uut (
		.clk(clk), .reset_n(reset_n), .chanCfg(cfg), .countInit(cInit),
		.reloadCount(rCnt), .countLoad(load), .waitStates(ws),
		.csNegateBetween(1'b1), .clkRatio(ratio),
		.transferRequest_n(reqN), .periphRequest(pReq), .nmiPin(nmiPin),
		.nmiFlagClear(nmiClr), .nmiFlag(nmiFlag),
		.transferEndFlagClear(teClr), .halfDoneFlagClear(hdClr),
		.transferEndFlag(teFlag), .halfDoneFlag(hdFlag),
		.finishInterrupt(finIrq), .halfInterrupt(halfIrq),
		.topIrqValid(topValid), .topIrqSource(topSrc), .busPins(pins),
		.busActive(busAct), .busChannel(busCh), .busRdData(rdData),
		.streamValid(sValid), .streamReady(sRdy), .streamData(sData)
	);

	dma_ext_partner dev (
		.clk(clk), .want(want), .busPins(pins),
		.transferRequest_n(reqN), .busRdData(rdData), .pieces(pieces)
	);

	always #4 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			badCount++;
			endSim();
		end
	end

	task automatic endSim();
		if (badCount == 0 && nChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// The channel is switched off for a cycle before its settings move.
	task automatic setCfg(int ch, bit edg, bit per, int sz, int wd, int mt,
		bit rd, bit ie, bit half_done_irq_enable);
		cfg[ch].channelEnable = 1'b0;
		@(negedge clk);
		cfg[ch] = '{1'b1, edg, ie, half_done_irq_enable, per, 1'b0, rd, xfer_size_t'(sz),
			dev_width_t'(wd), mem_type_t'(mt)};
	endtask

	task automatic loadCnt(int ch, int v);
		cInit[ch] = v[CNT_W-1:0];
		rCnt[ch] = v[CNT_W-1:0];
		load[ch] = 1'b1;
		@(negedge clk);
		load[ch] = 1'b0;
	endtask

	task automatic clrFlags(int ch, bit te, bit hd);
		teClr[ch] = te;
		hdClr[ch] = hd;
		@(negedge clk);
		teClr[ch] = 1'b0;
		hdClr[ch] = 1'b0;
		@(negedge clk);
	endtask

	task automatic waitStart(inout int n);
		while (busAct !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic kick(int ch, output int n);
		pReq[ch] = 1'b1;
		@(negedge clk);
		pReq[ch] = 1'b0;
		n = 1;
		waitStart(n);
	endtask

	// Counts strobe cycles of one unit, sampled where they are settled.
	task automatic runUnit();
		logic prevCs;
		csH = 0;
		ackH = 0;
		tdH = 0;
		csUp = 0;
		actH = 0;
		prevCs = 1'b0;
		while (busAct === 1'b1 && actH < 400) begin
			csH += pins.chipSelect;
			ackH += pins.requestAck;
			tdH += pins.transferEnd;
			csUp += (pins.chipSelect && !prevCs);
			prevCs = pins.chipSelect;
			actH++;
			@(negedge clk);
		end
		@(negedge clk);
	endtask

	initial begin
		int n, p, e;
		for (int c = 0; c < NUM_CH; c++) begin
			cfg[c] = '0;
			cInit[c] = '0;
			rCnt[c] = '0;
		end
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		`CHK("endFlag", 8'h00, teFlag)
		`CHK("pins", 3'b000, pins)
		for (int m = 0; m < 3; m++)
			for (int s = 0; s < 4; s++)
				for (int w = 0; w < 3; w++) begin
					ws = (m == 0) ? w[WAIT_W-1:0] : '0;
					setCfg(0, 0, 1, s, w, m, 1, 1, 0);
					loadCnt(0, 1);
					kick(0, n);
					`CHK("periphLatency", PERIPH_LAT + 1, n)
					`CHK("channel", 3'h0, busCh)
					runUnit();
					p = ((s == 3) ? 4 : s) - w;
					p = (p > 0) ? (1 << p) : 1;
					e = (m == 0) ? p * (w + 1) : 2 * p;
					`CHK("csPieces", p, csUp)
					`CHK("csCycles", e, csH)
					`CHK("ackCycles", (m == 0) ? e : p, ackH)
					`CHK("endCycles", e, tdH)
					`CHK("finishIrq", 1'b1, finIrq[0])
					clrFlags(0, 1, 1);
					`CHK("finishIrq", 1'b0, finIrq[0])
				end
		ws = '0;
		for (int r = 0; r < 8; r++) begin
			ratio = clk_ratio_t'(r >> 1);
			setCfg(0, 0, 1, 2, 2, 3, r[0], 1, 0);
			loadCnt(0, 1);
			kick(0, n);
			runUnit();
			e = ((r >> 1) == 3) ? 1 : (r == 1) ? 3 : 2;
			`CHK("ramCycles", e, actH)
			clrFlags(0, 1, 1);
		end
		setCfg(2, 0, 1, 0, 0, 0, 1, 1, 1);
		setCfg(5, 0, 1, 0, 0, 0, 1, 1, 0);
		loadCnt(2, 2);
		loadCnt(5, 1);
		kick(2, n);
		runUnit();
		`CHK("halfIrq", 8'h04, halfIrq)
		kick(5, n);
		runUnit();
		`CHK("halfFlag", 8'h24, hdFlag)
		`CHK("halfIrq", 8'h04, halfIrq)
		`CHK("topSource", 4'h5, topSrc)
		kick(2, n);
		runUnit();
		`CHK("finishIrq", 8'h24, finIrq)
		`CHK("topSource", 4'h4, topSrc)
		clrFlags(2, 1, 0);
		`CHK("topSource", 4'h5, topSrc)
		clrFlags(2, 0, 1);
		`CHK("topSource", 4'ha, topSrc)
		clrFlags(5, 1, 1);
		`CHK("topValid", 1'b0, topValid)
		setCfg(3, 0, 1, 2, 2, 0, 1, 1, 0);
		loadCnt(3, 1);
		nmiPin = 1'b1;
		kick(3, n);
		`CHK("nmiBlocksStart", 50, n)
		`CHK("nmiFlag", 1'b1, nmiFlag)
		cfg[3].channelEnable = 1'b0;
		nmiPin = 1'b0;
		nmiClr = 1'b1;
		@(negedge clk);
		nmiClr = 1'b0;
		@(negedge clk);
		`CHK("nmiFlag", 1'b0, nmiFlag)
		nmiPin = 1'b1;
		repeat (NMI_LAT + 1) @(negedge clk);
		`CHK("nmiFlag", 1'b1, nmiFlag)
		nmiClr = 1'b1;
		@(negedge clk);
		nmiClr = 1'b0;
		setCfg(1, 1, 0, 2, 2, 0, 1, 1, 0);
		loadCnt(1, 2);
		want[1] = 1'b1;
		n = 0;
		waitStart(n);
		`CHK("pinLatency", EXT_REQ_LAT + 2, n)
		runUnit();
		n = 0;
		waitStart(n);
		`CHK("oneUnitPerEdge", 50, n)
		want[1] = 1'b0;
		repeat (3) @(negedge clk);
		want[1] = 1'b1;
		n = 0;
		waitStart(n);
		`CHK("pinLatency", EXT_REQ_LAT + 2, n)
		runUnit();
		`CHK("endFlag", 1'b1, teFlag[1])
		want[1] = 1'b0;
		clrFlags(1, 1, 1);
		// Longwords to a 32-bit device keep the acknowledge whole.
		setCfg(1, 0, 0, 2, 2, 0, 1, 1, 0);
		loadCnt(1, 6);
		sRdy = 1'b0;
		p = pieces;
		want[1] = 1'b1;
		repeat (80) @(negedge clk);
		// A full buffer keeps the engine from starting the next unit.
		`CHK("stalledOnFull", 1'b0, busAct)
		`CHK("fifoValid", 1'b1, sValid)
		`CHK("piecesBeforeStall", p + 4, pieces)
		sRdy = 1'b1;
		for (int k = 0; k < 6; k++) begin
			n = 0;
			while (sValid !== 1'b1 && n < 50) begin
				@(negedge clk);
				n++;
			end
			`CHK("streamData", 32'ha5000000 + p + k, sData)
			@(negedge clk);
		end
		repeat (20) @(negedge clk);
		`CHK("noOverrun", p + 6, pieces)
		`CHK("endFlag", 1'b1, teFlag[1])
		`CHK("fifoEmpty", 1'b0, sValid)
		want[1] = 1'b0;
		endSim();
	end
endmodule
